// ### rtl/skd_operand_dec.sv
`timescale 1ns/1ns
package skd_pkg;
  localparam int OP_W = 5;
  typedef enum logic [4:0] {
    OP_OTHER     = 5'h00,
    OP_ADC_HL    = 5'h01,
    OP_SBC_HL    = 5'h02,
    OP_ADS_IMM   = 5'h03,
    OP_SBS       = 5'h04,
    OP_INCREMENT_SKIP      = 5'h05,
    OP_DECREMENT_SKIP      = 5'h06,
    OP_EXCHANGE_INCREMENT      = 5'h07,
    OP_EXCHANGE_DECREMENT      = 5'h08,
    OP_LDI       = 5'h09,
    OP_LDD       = 5'h0A,
    OP_BIT_TEST_TRUE_SKIP      = 5'h0B,
    OP_BIT_TEST_FALSE_SKIP      = 5'h0C,
    OP_COMPARE_SKIP_EQUAL      = 5'h0D,
    OP_SCF       = 5'h0E,
    OP_RCF       = 5'h0F,
    OP_CCF       = 5'h10,
    OP_RRC       = 5'h11,
    OP_LDB_C     = 5'h12,
    OP_BAND_C    = 5'h13,
    OP_BOR_C     = 5'h14,
    OP_CARRY_BIT_XOR_C    = 5'h15,
    OP_INTERRUPT_RETURN_OP      = 5'h16,
    OP_LD_A_IMM  = 5'h17,
    OP_LD_EA_IMM = 5'h18,
    OP_LD_HL_IMM = 5'h19,
    OP_REF       = 5'h1A,
    OP_BIT_MEMA  = 5'h1B,
    OP_BIT_MEMB  = 5'h1C,
    OP_BIT_PDA   = 5'h1D
  } skd_op_t;

  // operand classes seen by the field decoder
  typedef enum logic [1:0] {
    CLS_GENERAL    = 2'h0,
    CLS_RESTRICTED = 2'h1,
    CLS_PAIR       = 2'h2,
    CLS_INDIRECT   = 2'h3
  } skd_cls_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_PAIR = 2'b01,
    ST_SKIP = 2'b11
  } skd_state_t;

  // redundancy groups for consecutive immediate loads
  localparam logic [1:0] GRP_NONE = 2'h0;
  localparam logic [1:0] GRP_AEA  = 2'h1;
  localparam logic [1:0] GRP_HL   = 2'h2;

  localparam logic [2:0] REG_A    = 3'h0;
  localparam logic [2:0] IND_HL   = 3'h5;
  localparam logic [2:0] IND_WX   = 3'h6;
  localparam logic [2:0] IND_WL   = 3'h7;
  localparam logic [1:0] PTR_HL   = 2'h0;
  localparam logic [1:0] PTR_WX   = 2'h1;
  localparam logic [1:0] PTR_WL   = 2'h2;

  localparam logic [7:0] MEMA_PAGE_LO = 8'hFB;
  localparam logic [7:0] MEMA_PAGE_HI = 8'hFF;
  localparam logic [11:0] MEMB_BASE   = 12'hFC0;
  localparam logic [3:0] BANK_DEFAULT = 4'h0;

  localparam logic [13:0] REF_BASE  = 14'h0020;
  localparam logic [13:0] REF_LAST  = 14'h007F;

  localparam logic [1:0] SKIP_CYC_NONE  = 2'h0;
  localparam logic [1:0] SKIP_CYC_SHORT = 2'h1;
  localparam logic [1:0] SKIP_CYC_LONG  = 2'h2;
  localparam logic [1:0] LEN_LONG       = 2'h3;
  localparam int IMM_SHORT_W = 4;
  localparam int IMM_LONG_W  = 8;
endpackage : skd_pkg

module skd_operand_dec
  import skd_pkg::*;
(
  input  wire logic [2:0] field,
  input  wire skd_cls_t   cls,
  output logic      [7:0] regOneHot,
  output logic      [1:0] pairSel,
  output logic      [1:0] ptrSel,
  output logic            fieldErr
);
  always_comb begin
    regOneHot = 8'h00;
    pairSel   = 2'h0;
    ptrSel    = PTR_HL;
    fieldErr  = 1'b0;
    case (cls)
      CLS_GENERAL: regOneHot = 8'h01 << field;
      CLS_RESTRICTED: begin
        regOneHot = 8'h01 << field;
        fieldErr  = (field == REG_A);
      end
      CLS_PAIR: begin
        pairSel  = field[2:1];
        fieldErr = field[0];
      end
      CLS_INDIRECT: begin
        case (field)
          IND_HL:  ptrSel = PTR_HL;
          IND_WX:  ptrSel = PTR_WX;
          IND_WL:  ptrSel = PTR_WL;
          default: fieldErr = 1'b1;
        endcase
      end
      default: fieldErr = 1'b1;
    endcase
  end
endmodule : skd_operand_dec

// ### rtl/skd_skip_decode.sv
`timescale 1ns/1ns
// Behaviour
// - three bit addressing modes are decoded: direct I/O bit, port bit via L, and H plus direct.
// - direct bit addressing reaches only FB0H-FBFH and FF0H-FFFH.
// - H plus direct bit addressing reaches the bank set by the bank enable flag and bank number.
// - increment/decrement style skip instructions skip on overflow or borrow, carry untouched.
// - bit tests and compare-equal skip when their condition holds, carry untouched.
// - carry-only instructions update carry and never skip.
// - an add-immediate-with-skip right after add/subtract-with-carry on @HL never skips.
// - in that pair add skips the add-immediate on overflow, subtract on no borrow.
// - a reference keeps the load history; a redundant load right after it is skipped.
// - register field encodes A,E,L,H,X,W,Z,Y and pairs EA,HL,WX,YZ.
// - indirect field 101 is HL, 110 is WX, 111 is WL.
// - general class takes all eight registers, restricted class excludes the accumulator.
// - short immediates are 4 bits, long immediates 8 bits.
// - consecutive immediate loads to A/EA or to HL execute only the first.
// - a skip costs 1 or 2 extra cycles by the length of the skipped instruction, a skipped reference always 1.
module skd_skip_decode
  import skd_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         instValid,
  input  wire skd_op_t      instOp,
  input  wire logic   [1:0] instLen,
  input  wire logic   [2:0] operandField,
  input  wire skd_cls_t     operandCls,
  input  wire logic   [7:0] immByte,
  input  wire logic         aluOverflow,
  input  wire logic         aluBorrow,
  input  wire logic         bitValue,
  input  wire logic         cmpEqual,
  input  wire logic   [3:0] bitLowAddr,
  input  wire logic         memaHighPage,
  input  wire logic   [1:0] bitIndex,
  input  wire logic   [3:0] ptrLow,
  input  wire logic   [3:0] ptrHigh,
  input  wire logic         memoryBankEnableFlag,
  input  wire logic   [3:0] memoryBankSelect,
  output logic              decValid_ff,
  output logic              suppress_ff,
  output logic              skipTaken_ff,
  output logic        [1:0] skipCycles_ff,
  output logic              carryUpdate_ff,
  output logic        [7:0] regOneHot_ff,
  output logic        [1:0] pairSel_ff,
  output logic        [1:0] ptrSel_ff,
  output logic              fieldErr_ff,
  output logic        [7:0] immData_ff,
  output logic              immWide_ff,
  output logic              bitValid_ff,
  output logic       [11:0] bitAddr_ff,
  output logic        [1:0] bitIdx_ff,
  output logic        [3:0] bitBank_ff,
  output logic       [13:0] refAddr_ff
);
  skd_state_t state_ff;
  skd_state_t nxt_state;
  logic       pairCond_ff;
  logic       nxt_pairCond;
  logic [1:0] lastGrp_ff;
  logic [1:0] nxt_lastGrp;
  logic       nxt_suppress;
  logic [1:0] nxt_skipCycles;
  logic       nxt_carryUpdate;
  logic       execute;
  logic       skipCond;
  logic [1:0] grp;
  logic [7:0] decOneHot;
  logic [1:0] decPair;
  logic [1:0] decPtr;
  logic       decErr;

  function automatic logic [1:0] skip_cost(input logic [1:0] len, input skd_op_t op);
    if (op == OP_REF) begin
      skip_cost = SKIP_CYC_SHORT;
    end else if (len == LEN_LONG) begin
      skip_cost = SKIP_CYC_LONG;
    end else begin
      skip_cost = SKIP_CYC_SHORT;
    end
  endfunction : skip_cost

  function automatic logic [1:0] load_group(input skd_op_t op);
    case (op)
      OP_LD_A_IMM, OP_LD_EA_IMM: load_group = GRP_AEA;
      OP_LD_HL_IMM:              load_group = GRP_HL;
      default:                   load_group = GRP_NONE;
    endcase
  endfunction : load_group

  skd_operand_dec u_operand_dec (
    .field     (operandField),
    .cls       (operandCls),
    .regOneHot (decOneHot),
    .pairSel   (decPair),
    .ptrSel    (decPtr),
    .fieldErr  (decErr)
  );

  assign grp = load_group(instOp);

  always_comb begin
    case (instOp)
      OP_INCREMENT_SKIP, OP_EXCHANGE_INCREMENT, OP_LDI, OP_ADS_IMM: skipCond = aluOverflow;
      OP_DECREMENT_SKIP, OP_EXCHANGE_DECREMENT, OP_LDD, OP_SBS:     skipCond = aluBorrow;
      OP_BIT_TEST_TRUE_SKIP:                              skipCond = bitValue;
      OP_BIT_TEST_FALSE_SKIP:                              skipCond = !bitValue;
      OP_COMPARE_SKIP_EQUAL:                              skipCond = cmpEqual;
      default:                              skipCond = 1'b0;
    endcase
  end

  always_comb begin
    nxt_state       = state_ff;
    nxt_pairCond    = pairCond_ff;
    nxt_lastGrp     = lastGrp_ff;
    nxt_suppress    = 1'b0;
    nxt_skipCycles  = SKIP_CYC_NONE;
    nxt_carryUpdate = 1'b0;
    execute         = 1'b0;
    if (instValid) begin
      nxt_state = ST_RUN;
      case (state_ff)
        ST_SKIP: begin
          // fetched only; nothing of it takes effect
          nxt_suppress   = 1'b1;
          nxt_skipCycles = skip_cost(instLen, instOp);
          nxt_lastGrp    = GRP_NONE;
        end
        ST_PAIR: begin
          if (instOp == OP_ADS_IMM) begin
            if (pairCond_ff) begin
              nxt_suppress   = 1'b1;
              nxt_skipCycles = skip_cost(instLen, instOp);
            end else begin
              execute = 1'b1;
            end
            nxt_lastGrp = GRP_NONE;
          end else begin
            execute = 1'b1;
          end
        end
        ST_RUN:  execute = 1'b1;
        default: execute = 1'b1;
      endcase
      if (execute) begin
        if (grp != GRP_NONE && grp == lastGrp_ff) begin
          // redundant load behaves as a no-operation
          nxt_suppress = 1'b1;
        end else begin
          // a reference keeps the load history so that a load right after it is redundant
          nxt_lastGrp = (instOp == OP_REF) ? lastGrp_ff : grp;
          case (instOp)
            OP_ADC_HL, OP_SBC_HL: begin
              nxt_carryUpdate = 1'b1;
              nxt_pairCond    = (instOp == OP_ADC_HL) ? aluOverflow : !aluBorrow;
              nxt_state       = ST_PAIR;
            end
            OP_SCF, OP_RCF, OP_CCF, OP_RRC, OP_LDB_C, OP_BAND_C, OP_BOR_C, OP_CARRY_BIT_XOR_C,
            OP_INTERRUPT_RETURN_OP: nxt_carryUpdate = 1'b1;
            default: begin
              // an add-immediate following the pair never skips
              if (skipCond && !(state_ff == ST_PAIR && instOp == OP_ADS_IMM)) begin
                nxt_state = ST_SKIP;
              end
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff    <= ST_RUN;
      pairCond_ff <= 1'b0;
      lastGrp_ff  <= GRP_NONE;
    end else begin
      state_ff    <= nxt_state;
      pairCond_ff <= nxt_pairCond;
      lastGrp_ff  <= nxt_lastGrp;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      decValid_ff    <= 1'b0;
      suppress_ff    <= 1'b0;
      skipTaken_ff   <= 1'b0;
      skipCycles_ff  <= SKIP_CYC_NONE;
      carryUpdate_ff <= 1'b0;
    end else begin
      decValid_ff    <= instValid;
      suppress_ff    <= nxt_suppress;
      skipTaken_ff   <= instValid && (nxt_state == ST_SKIP);
      skipCycles_ff  <= nxt_skipCycles;
      carryUpdate_ff <= nxt_carryUpdate;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      regOneHot_ff <= 8'h00;
      pairSel_ff   <= 2'h0;
      ptrSel_ff    <= PTR_HL;
      fieldErr_ff  <= 1'b0;
      immData_ff   <= 8'h00;
      immWide_ff   <= 1'b0;
    end else if (instValid) begin
      regOneHot_ff <= nxt_suppress ? 8'h00 : decOneHot;
      pairSel_ff   <= decPair;
      ptrSel_ff    <= decPtr;
      fieldErr_ff  <= decErr;
      immWide_ff   <= (instOp == OP_LD_EA_IMM) || (instOp == OP_LD_HL_IMM);
      if ((instOp == OP_LD_EA_IMM) || (instOp == OP_LD_HL_IMM)) begin
        immData_ff <= immByte[IMM_LONG_W-1:0];
      end else begin
        immData_ff <= {4'h0, immByte[IMM_SHORT_W-1:0]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bitValid_ff <= 1'b0;
      bitAddr_ff  <= 12'h000;
      bitIdx_ff   <= 2'h0;
      bitBank_ff  <= BANK_DEFAULT;
      refAddr_ff  <= REF_BASE;
    end else begin
      bitValid_ff <= 1'b0;
      if (instValid && !nxt_suppress) begin
        case (instOp)
          OP_BIT_MEMA: begin
            bitValid_ff <= 1'b1;
            bitAddr_ff  <= {memaHighPage ? MEMA_PAGE_HI : MEMA_PAGE_LO, bitLowAddr};
            bitIdx_ff   <= bitIndex;
            bitBank_ff  <= BANK_DEFAULT;
          end
          OP_BIT_MEMB: begin
            bitValid_ff <= 1'b1;
            bitAddr_ff  <= MEMB_BASE | {6'h00, ptrLow[3:2], bitLowAddr};
            bitIdx_ff   <= ptrLow[1:0];
            bitBank_ff  <= BANK_DEFAULT;
          end
          OP_BIT_PDA: begin
            bitValid_ff <= 1'b1;
            bitAddr_ff  <= {4'h0, ptrHigh, bitLowAddr};
            bitIdx_ff   <= bitIndex;
            bitBank_ff  <= memoryBankEnableFlag ? memoryBankSelect : BANK_DEFAULT;
          end
          OP_REF: begin
            // table entries are even; the address is twice the operand ORed with REF_BASE
            refAddr_ff <= {7'h00, immByte[5:0], 1'b0} | REF_BASE;
          end
          default: bitValid_ff <= 1'b0;
        endcase
      end
    end
  end
endmodule : skd_skip_decode

// ### test/skd_skip_asserts.sv
`timescale 1ns/1ns
module skd_skip_asserts
  import skd_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       instValid,
  input wire skd_op_t    instOp,
  input wire logic [1:0] instLen,
  input wire logic       aluOverflow,
  input wire logic       aluBorrow,
  input wire logic       bitValue,
  input wire logic       cmpEqual,
  input wire logic       decValid_ff,
  input wire logic       suppress_ff,
  input wire logic       skipTaken_ff,
  input wire logic [1:0] skipCycles_ff,
  input wire logic       carryUpdate_ff,
  input wire logic [7:0] regOneHot_ff
);
  // instruction right after a valid one that asked for no skip
  wire logic clean = decValid_ff && !skipTaken_ff && instValid;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  AST_SKIP_COUNT: assert property (
    clean && (aluOverflow && instOp inside {OP_INCREMENT_SKIP, OP_EXCHANGE_INCREMENT, OP_LDI} ||
    aluBorrow && instOp inside {OP_DECREMENT_SKIP, OP_EXCHANGE_DECREMENT, OP_LDD, OP_SBS})
    |=> skipTaken_ff && !carryUpdate_ff) else $error("count skip missing");
  AST_SKIP_COND: assert property (
    clean && (instOp == OP_BIT_TEST_TRUE_SKIP && bitValue || instOp == OP_BIT_TEST_FALSE_SKIP && !bitValue ||
    instOp == OP_COMPARE_SKIP_EQUAL && cmpEqual) |=> skipTaken_ff && !carryUpdate_ff)
    else $error("condition skip missing");
  AST_CARRY_ONLY: assert property (
    clean && instOp inside {OP_ADC_HL, OP_SBC_HL, [OP_SCF:OP_INTERRUPT_RETURN_OP]}
    |=> carryUpdate_ff && !skipTaken_ff) else $error("carry op wrong");
  AST_SKIP_LONG: assert property (
    instValid && skipTaken_ff && instLen == 2'h3 && instOp != OP_REF
    |=> suppress_ff && skipCycles_ff == SKIP_CYC_LONG && regOneHot_ff == 8'h00)
    else $error("long skip wrong");
  AST_SKIP_SHORT: assert property (
    instValid && skipTaken_ff && (instLen != 2'h3 || instOp == OP_REF)
    |=> suppress_ff && skipCycles_ff == SKIP_CYC_SHORT) else $error("short skip wrong");
  AST_PAIR_ADS: assert property (
    clean && instOp inside {OP_ADC_HL, OP_SBC_HL} ##1 instValid && instOp == OP_ADS_IMM
    |=> !skipTaken_ff) else $error("paired add skipped");
  AST_PAIR_JUMP: assert property (
    clean && (instOp == OP_ADC_HL && aluOverflow || instOp == OP_SBC_HL && !aluBorrow)
    ##1 instValid && instOp == OP_ADS_IMM && instLen != 2'h3
    |=> suppress_ff && skipCycles_ff == SKIP_CYC_SHORT) else $error("pair jump missing");
  AST_REDUNDANT_HL: assert property (
    clean && instOp == OP_LD_HL_IMM ##1 instValid && instOp == OP_LD_HL_IMM
    |=> suppress_ff && skipCycles_ff == SKIP_CYC_NONE) else $error("redundant load ran");
endmodule : skd_skip_asserts

// ### test/tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
bind skd_skip_decode skd_skip_asserts u_chk (.*);
module tb_top;
  import skd_pkg::*;
  typedef struct {skd_op_t op; logic c; logic sk; logic cy;} skd_row_t;
  logic        clk = 1'b0, reset = 1'b1, instValid = 1'b0, memaHighPage = 1'b0;
  logic        aluOverflow = 1'b0, aluBorrow = 1'b0, bitValue = 1'b0, cmpEqual = 1'b0;
  logic        memoryBankEnableFlag = 1'b0;
  skd_op_t     instOp = OP_OTHER;
  skd_cls_t    operandCls = CLS_GENERAL;
  logic [1:0]  instLen = 2'h1, bitIndex = 2'h0;
  logic [2:0]  operandField = 3'h0;
  logic [7:0]  immByte = 8'hA7;
  logic [3:0]  bitLowAddr = 4'h0, ptrLow = 4'h0, ptrHigh = 4'h0, memoryBankSelect = 4'h0;
  logic        decValid_ff, suppress_ff, skipTaken_ff, carryUpdate_ff, fieldErr_ff;
  logic        immWide_ff, bitValid_ff;
  logic [1:0]  skipCycles_ff, pairSel_ff, ptrSel_ff, bitIdx_ff;
  logic [7:0]  regOneHot_ff, immData_ff;
  logic [11:0] bitAddr_ff;
  logic [3:0]  bitBank_ff;
  logic [13:0] refAddr_ff;
  int          failures = 0, total_checks = 0;
  skd_row_t    rows[$] = '{
    '{OP_INCREMENT_SKIP,1,1,0}, '{OP_INCREMENT_SKIP,0,0,0}, '{OP_EXCHANGE_INCREMENT,1,1,0}, '{OP_LDI,1,1,0},
    '{OP_ADS_IMM,1,1,0}, '{OP_DECREMENT_SKIP,1,1,0}, '{OP_EXCHANGE_DECREMENT,1,1,0}, '{OP_LDD,1,1,0},
    '{OP_SBS,1,1,0}, '{OP_SBS,0,0,0}, '{OP_BIT_TEST_TRUE_SKIP,1,1,0}, '{OP_BIT_TEST_TRUE_SKIP,0,0,0},
    '{OP_BIT_TEST_FALSE_SKIP,0,1,0}, '{OP_BIT_TEST_FALSE_SKIP,1,0,0}, '{OP_COMPARE_SKIP_EQUAL,1,1,0}, '{OP_COMPARE_SKIP_EQUAL,0,0,0},
    '{OP_ADC_HL,1,0,1}, '{OP_SBC_HL,1,0,1}, '{OP_SCF,1,0,1}, '{OP_RCF,1,0,1},
    '{OP_CCF,1,0,1}, '{OP_RRC,1,0,1}, '{OP_LDB_C,1,0,1}, '{OP_BAND_C,1,0,1},
    '{OP_BOR_C,1,0,1}, '{OP_CARRY_BIT_XOR_C,1,0,1}, '{OP_INTERRUPT_RETURN_OP,1,0,1}};
  skd_op_t     seqOp[12] = '{OP_LD_A_IMM, OP_LD_EA_IMM, OP_LD_A_IMM, OP_OTHER, OP_LD_HL_IMM,
    OP_LD_HL_IMM, OP_LD_A_IMM, OP_LD_EA_IMM, OP_REF, OP_LD_EA_IMM, OP_OTHER, OP_OTHER};
  logic        seqSup[11] = '{0, 1, 1, 0, 0, 1, 0, 1, 0, 1, 0};
  skd_skip_decode uut (.*);
  initial forever #5 clk = ~clk;
  task automatic send(skd_op_t op, logic [1:0] len, logic [2:0] f, skd_cls_t cl, logic c,
                      logic v);
    @(negedge clk);
    instValid = v;
    instOp = op;
    instLen = len;
    operandField = f;
    operandCls = cl;
    aluOverflow = c;
    aluBorrow = c;
    bitValue = c;
    cmpEqual = c;
  endtask : send
  task automatic op1(skd_op_t op, logic c);
    send(op, 2'h1, 3'h1, CLS_GENERAL, c, 1'b1);
  endtask : op1
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    `CHK("refAddr", 14'h0020, refAddr_ff)
    `CHK("bitBank", 4'h0, bitBank_ff)
    foreach (rows[i]) begin
      op1(rows[i].op, rows[i].c);
      send(OP_OTHER, i[0] ? 2'h1 : 2'h3, 3'h1, CLS_GENERAL, 1'b0, 1'b1);
      `CHK("skipTaken", rows[i].sk, skipTaken_ff)
      `CHK("carryUpdate", rows[i].cy, carryUpdate_ff)
      op1(OP_OTHER, 1'b0);
      `CHK("suppress", rows[i].sk, suppress_ff)
      `CHK("cycles", rows[i].sk ? (i[0] ? 2'h1 : 2'h2) : 2'h0, skipCycles_ff)
      `CHK("regOneHot", rows[i].sk ? 8'h00 : 8'h02, regOneHot_ff)
    end
    $display("test table done");
    for (int k = 0; k < 4; k++) begin
      op1(k[1] ? OP_SBC_HL : OP_ADC_HL, k[0]);
      op1(OP_ADS_IMM, 1'b1);
      op1(OP_OTHER, 1'b0);
      `CHK("pairSkip", 1'b0, skipTaken_ff)
      `CHK("adsSuppress", k[1] ^ k[0], suppress_ff)
      op1(OP_OTHER, 1'b0);
      `CHK("adsSkip", 1'b0, skipTaken_ff)
      op1(OP_OTHER, 1'b0);
      `CHK("third", 1'b0, suppress_ff)
    end
    $display("test pairing done");
    op1(seqOp[0], 1'b0);
    for (int i = 1; i < 12; i++) begin
      op1(seqOp[i], 1'b0);
      `CHK("redundant", seqSup[i-1], suppress_ff)
      if (i == 1) `CHK("immShort", 9'h007, {immWide_ff, immData_ff})
      if (i == 5) `CHK("immLong", 9'h1A7, {immWide_ff, immData_ff})
      if (i == 9) `CHK("refAddr", 14'h006E, refAddr_ff)
    end
    $display("test redundancy done");
    for (int f = 0; f < 8; f++) begin
      send(OP_OTHER, 2'h1, 3'(f), CLS_GENERAL, 1'b0, 1'b1);
      send(OP_OTHER, 2'h1, 3'(f), CLS_RESTRICTED, 1'b0, 1'b1);
      `CHK("general", 8'h01 << f, regOneHot_ff)
      send(OP_OTHER, 2'h1, 3'(f), CLS_PAIR, 1'b0, 1'b1);
      `CHK("restricted", f == 0, fieldErr_ff)
      send(OP_OTHER, 2'h1, 3'(f), CLS_INDIRECT, 1'b0, 1'b1);
      if (!f[0]) `CHK("pair", 2'(f / 2), pairSel_ff)
      op1(OP_OTHER, 1'b0);
      if (f >= 5) `CHK("indirect", 2'(f - 5), ptrSel_ff)
    end
    $display("test operand done");
    memoryBankEnableFlag = 1'b1;
    memoryBankSelect = 4'h3;
    ptrHigh = 4'h2;
    ptrLow = 4'hE;
    bitLowAddr = 4'h5;
    bitIndex = 2'h1;
    op1(OP_BIT_PDA, 1'b0);
    op1(OP_BIT_MEMA, 1'b0);
    `CHK("pda", 19'h0129B, {bitAddr_ff, bitBank_ff, bitIdx_ff, bitValid_ff})
    op1(OP_BIT_MEMB, 1'b0);
    `CHK("memaLow", 12'hFB5, bitAddr_ff)
    send(OP_OTHER, 2'h1, 3'h1, CLS_GENERAL, 1'b0, 1'b0);
    `CHK("memb", 14'h3FD6, {bitAddr_ff, bitIdx_ff})
    memaHighPage = 1'b1;
    memoryBankEnableFlag = 1'b0;
    op1(OP_BIT_MEMA, 1'b0);
    op1(OP_BIT_PDA, 1'b0);
    `CHK("memaHigh", 12'hFF5, bitAddr_ff)
    op1(OP_OTHER, 1'b0);
    `CHK("bankOff", 5'h01, {bitBank_ff, bitValid_ff})
    $display("test bit done");
    op1(OP_INCREMENT_SKIP, 1'b1);
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    instValid = 1'b0;
    `CHK("resetSkip", 1'b0, skipTaken_ff)
    `CHK("resetRef", 14'h0020, refAddr_ff)
    $display("test reset done");
    tally_and_finish();
  end
endmodule : tb_top
